// ### inc/hart_pkg.sv
// Function
// - all three counters tick from the one counter clock input pin
// - counter zero and counter one gates are always active
// - counter two gate is a flop loaded from data bit 0 on gate-port writes
// - counter zero output drives the internal timer interrupt line only
// - counter one output feeds the arbiter as refresh source
// - counter two output drives the speaker timer pin
// - writes at 040-042 load counts; reads return live or latched count or status
// - write at 043 is control word, latch or read-back; read at 043 does nothing
// - arbiter sources are dma hold request and counter one rising edge
// - dma request sampled on dma clock rise, refresh request on its fall
// - first captured request wins, dma if both are pending at idle; the other waits until it completes
// - at end of hold, serve other requester with host hold kept high
// - dma win raises host hold, dma acknowledge only after host grant
// - after dma release, refresh if pending, else drop host hold
// - refresh win raises host hold; on grant the strobe is driven low
// - strobe low four bus clock rises, then released and host hold dropped
// - dma request pending at end of refresh is acknowledged next
// - channel ready low at the fourth edge stretches strobe until it returns
// - strobe is open drain low only; external low parks an idle arbiter, with no host hold and no strobe, until the line rises
package hart_pkg;
  localparam logic [7:0] CNT0_ADDR    = 8'h40;
  localparam logic [7:0] CNT1_ADDR    = 8'h41;
  localparam logic [7:0] CNT2_ADDR    = 8'h42;
  localparam logic [7:0] CTRL_ADDR    = 8'h43;
  localparam logic [7:0] GATE_ADDR    = 8'h61;
  localparam int         GATE_BIT     = 0;
  localparam int         REFRESH_EDGES = 4;
  localparam int         READY_EDGE   = 3;
  typedef enum logic [2:0] {
    ARB_IDLE  = 3'b000,
    ARB_DWAIT = 3'b001,
    ARB_DMA   = 3'b010,
    ARB_RWAIT = 3'b011,
    ARB_REF   = 3'b100,
    ARB_EXT   = 3'b101
  } hart_arb_t;
endpackage

// ### src/hart_sync.sv
`timescale 1ns/1ps
module hart_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // hart_sync

// ### src/hart_counter.sv
`timescale 1ns/1ps
// one counter channel; modes 0..5 in binary counting only, bcd not served
module hart_counter (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       gate,
  input  wire logic       ctrl_we,
  input  wire logic [5:0] ctrl_mode,
  input  wire logic       latch_cmd,
  input  wire logic       status_cmd,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            out
);
  logic [1:0]  rw_r;
  logic [2:0]  mode_r;
  logic [15:0] init_r;
  logic [15:0] cnt_r;
  logic [15:0] olat_r;
  logic [7:0]  stat_r;
  logic        olat_v_r;
  logic        stat_v_r;
  logic        wlo_r;
  logic        rlo_r;
  logic        null_r;
  logic        load_r;
  logic        gate_d_r;
  // a two-byte count is only complete once its high byte has landed
  wire         wr_done  = wr && (rw_r != 2'b11 || wlo_r);
  wire         trig     = gate && !gate_d_r;
  wire         periodic = mode_r[1];
  wire  [15:0] rd_src   = olat_v_r ? olat_r : cnt_r;
  wire  [15:0] reload   = (mode_r[1:0] == 2'b11) ? {init_r[15:1], 1'b0} : init_r;
  wire  [7:0]  rd_byte  = (rw_r == 2'b10 || (rw_r == 2'b11 && rlo_r)) ? rd_src[15:8]
                                                                      : rd_src[7:0];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rw_r <= 2'b11; mode_r <= 3'h0; init_r <= 16'h0000; cnt_r <= 16'h0000;
      olat_r <= 16'h0000; stat_r <= 8'h00; olat_v_r <= 1'b0; stat_v_r <= 1'b0;
      wlo_r <= 1'b0; rlo_r <= 1'b0; null_r <= 1'b1; load_r <= 1'b0;
      gate_d_r <= 1'b0; out <= 1'b0; rdata <= 8'h00;
    end else begin
      if (tick) gate_d_r <= gate;
      if (ctrl_we) begin
        rw_r <= ctrl_mode[5:4]; mode_r <= ctrl_mode[3:1];
        wlo_r <= 1'b0; rlo_r <= 1'b0; null_r <= 1'b1;
        out <= (ctrl_mode[3:1] != 3'h0);
      end
      if (latch_cmd && !olat_v_r) begin
        olat_r <= cnt_r; olat_v_r <= 1'b1;
      end
      if (status_cmd && !stat_v_r) begin
        stat_r <= {out, null_r, rw_r, mode_r, 1'b0}; stat_v_r <= 1'b1;
      end
      if (wr) begin
        unique case (rw_r)
          2'b01:   init_r[7:0]  <= wdata;
          2'b10:   init_r[15:8] <= wdata;
          default: begin
            if (!wlo_r) init_r[7:0] <= wdata;
            else        init_r[15:8] <= wdata;
            wlo_r <= !wlo_r;
          end
        endcase
        if (wr_done) begin
          null_r <= 1'b1; load_r <= 1'b1;
          if (mode_r == 3'h0) out <= 1'b0;
        end
      end
      if (rd) begin
        if (stat_v_r) begin
          rdata <= stat_r; stat_v_r <= 1'b0;
        end else begin
          rdata <= rd_byte;
          if (rw_r == 2'b11) rlo_r <= !rlo_r;
          if (rw_r != 2'b11 || rlo_r) olat_v_r <= 1'b0;
        end
      end
      if (tick) begin
        if (load_r && (!mode_r[0] || periodic || trig)) begin
          cnt_r <= reload; load_r <= 1'b0; null_r <= 1'b0;
          if (mode_r[2:1] == 2'b00 && mode_r[0]) out <= 1'b0;
        end else if (mode_r[0] && !periodic && trig) begin
          cnt_r <= reload; out <= (mode_r == 3'h5) ? 1'b1 : 1'b0;
        end else if (gate || (mode_r[0] && !periodic)) begin
          cnt_r <= cnt_r - (mode_r[1:0] == 2'b11 ? 16'h0002 : 16'h0001);
          unique case (mode_r[1:0])
            2'b10: begin
              if (cnt_r == 16'h0002) out <= 1'b0;
              else if (cnt_r == 16'h0001) begin
                out <= 1'b1; cnt_r <= init_r;
              end
            end
            2'b11: if (cnt_r == 16'h0002) begin
              out <= !out; cnt_r <= reload;
            end
            default: begin
              if (cnt_r == 16'h0001 && mode_r[2]) out <= 1'b0;
              else if (cnt_r == 16'h0001) out <= 1'b1;
              else if (mode_r[2]) out <= 1'b1;
            end
          endcase
        end
      end
    end
  end
endmodule // hart_counter

// ### src/hart_top.sv
`timescale 1ns/1ps
module hart_top (
  input  wire logic       REF_CLK,
  input  wire logic       RSTN,
  input  wire logic       COUNTER_CLOCK_INPUT,
  input  wire logic       SYSTEM_BUS_CLOCK,
  input  wire logic       DMA_CLOCK,
  input  wire logic [7:0] IO_ADDR,
  input  wire logic       PERIPHERAL_IO_READ_N,
  input  wire logic       PERIPHERAL_IO_WRITE_N,
  input  wire logic [7:0] IO_WDATA,
  output logic      [7:0] IO_RDATA,
  output logic            IO_RDATA_OE,
  output logic            TIMER_INTERRUPT_LINE,
  output logic            SPEAKER_TIMER_PIN,
  input  wire logic       DMA_HOLD_REQ,
  output logic            DMA_HOLD_ACK,
  output logic            HOST_HOLD_REQUEST,
  input  wire logic       HOST_HOLD_GRANT,
  input  wire logic       CHANNEL_READY_EXTEND,
  input  wire logic       REFRESH_IN,
  output logic            REFRESH_OUT,
  output logic            REFRESH_OE
);
  import hart_pkg::*;

  logic       cclk_s;
  logic       sclk_s;
  logic       dclk_s;
  logic       rd_n_s;
  logic       wr_n_s;
  logic       hlda_s;
  logic       dreq_s;
  logic       rdy_s;
  logic       refin_s;
  logic       cclk_d_r;
  logic       sclk_d_r;
  logic       dclk_d_r;
  logic       rd_n_d_r;
  logic       wr_n_d_r;
  logic       gate2_r;
  logic       out1_d_r;
  logic       ref_pend_r;
  logic       dma_pend_r;
  logic       oe_r;
  logic [2:0] edges_r;
  logic [1:0] oe_d_r;
  logic       ref_raw_r;
  logic       rd_go_r;
  logic [15:0] bus_m_r;
  logic [15:0] bus_s_r;
  hart_arb_t  st_r;
  hart_arb_t  st_nxt;

  hart_sync u_s0 (.clk(REF_CLK), .rst_n(RSTN), .d(COUNTER_CLOCK_INPUT), .q(cclk_s));
  hart_sync u_s1 (.clk(REF_CLK), .rst_n(RSTN), .d(SYSTEM_BUS_CLOCK), .q(sclk_s));
  hart_sync u_s2 (.clk(REF_CLK), .rst_n(RSTN), .d(DMA_CLOCK), .q(dclk_s));
  hart_sync #(.RST_VAL(1'b1)) u_s3 (.clk(REF_CLK), .rst_n(RSTN),
                                    .d(PERIPHERAL_IO_READ_N), .q(rd_n_s));
  hart_sync #(.RST_VAL(1'b1)) u_s4 (.clk(REF_CLK), .rst_n(RSTN),
                                    .d(PERIPHERAL_IO_WRITE_N), .q(wr_n_s));
  hart_sync u_s5 (.clk(REF_CLK), .rst_n(RSTN), .d(HOST_HOLD_GRANT), .q(hlda_s));
  hart_sync u_s6 (.clk(REF_CLK), .rst_n(RSTN), .d(DMA_HOLD_REQ), .q(dreq_s));
  hart_sync #(.RST_VAL(1'b1)) u_s7 (.clk(REF_CLK), .rst_n(RSTN),
                                    .d(CHANNEL_READY_EXTEND), .q(rdy_s));
  hart_sync #(.RST_VAL(1'b1)) u_s8 (.clk(REF_CLK), .rst_n(RSTN), .d(REFRESH_IN),
                                    .q(refin_s));

  // edge enables: counter clock is a pin, so it becomes a one-cycle tick here
  wire cnt_tick  = cclk_s && !cclk_d_r;
  wire sclk_rise = sclk_s && !sclk_d_r;
  wire dclk_rise = dclk_s && !dclk_d_r;
  wire dclk_fall = !dclk_s && dclk_d_r;
  // io strobes act once, on the leading edge, so a long pulse is one access
  wire io_wr     = !wr_n_s && wr_n_d_r;
  wire io_rd     = !rd_n_s && rd_n_d_r;

  // address and data pins stand across the strobe, so a two-flop copy lines up with it
  wire [7:0] addr_s  = bus_s_r[15:8];
  wire [7:0] wdata_s = bus_s_r[7:0];

  wire sel0  = addr_s == CNT0_ADDR;
  wire sel1  = addr_s == CNT1_ADDR;
  wire sel2  = addr_s == CNT2_ADDR;
  wire selc  = addr_s == CTRL_ADDR;
  wire selg  = addr_s == GATE_ADDR;
  wire cwr   = io_wr && selc;
  wire [1:0] csel = wdata_s[7:6];
  wire is_rb  = cwr && csel == 2'b11;
  wire is_lat = cwr && csel != 2'b11 && wdata_s[5:4] == 2'b00;
  wire is_cw  = cwr && csel != 2'b11 && wdata_s[5:4] != 2'b00;

  wire [2:0] ctrl_we;
  wire [2:0] latch;
  wire [2:0] stat;
  wire [2:0] wr_c = {io_wr && sel2, io_wr && sel1, io_wr && sel0};
  wire [2:0] rd_c = {io_rd && sel2, io_rd && sel1, io_rd && sel0};
  wire [2:0] gate = {gate2_r, 1'b1, 1'b1};
  wire [2:0] outs;
  wire [7:0] rd0;
  wire [7:0] rd1;
  wire [7:0] rd2;

  genvar g;
  for (g = 0; g < 3; g++) begin : g_ctl
    assign ctrl_we[g] = is_cw && csel == 2'(g);
    assign latch[g]   = (is_lat && csel == 2'(g)) ||
                        (is_rb && !wdata_s[5] && wdata_s[g + 1]);
    assign stat[g]    = is_rb && !wdata_s[4] && wdata_s[g + 1];
  end

  hart_counter u_c0 (.clk(REF_CLK), .rst_n(RSTN), .tick(cnt_tick), .gate(gate[0]),
                     .ctrl_we(ctrl_we[0]), .ctrl_mode(wdata_s[5:0]),
                     .latch_cmd(latch[0]), .status_cmd(stat[0]), .wr(wr_c[0]),
                     .rd(rd_c[0]), .wdata(wdata_s), .rdata(rd0), .out(outs[0]));
  hart_counter u_c1 (.clk(REF_CLK), .rst_n(RSTN), .tick(cnt_tick), .gate(gate[1]),
                     .ctrl_we(ctrl_we[1]), .ctrl_mode(wdata_s[5:0]),
                     .latch_cmd(latch[1]), .status_cmd(stat[1]), .wr(wr_c[1]),
                     .rd(rd_c[1]), .wdata(wdata_s), .rdata(rd1), .out(outs[1]));
  hart_counter u_c2 (.clk(REF_CLK), .rst_n(RSTN), .tick(cnt_tick), .gate(gate[2]),
                     .ctrl_we(ctrl_we[2]), .ctrl_mode(wdata_s[5:0]),
                     .latch_cmd(latch[2]), .status_cmd(stat[2]), .wr(wr_c[2]),
                     .rd(rd_c[2]), .wdata(wdata_s), .rdata(rd2), .out(outs[2]));

  assign TIMER_INTERRUPT_LINE = outs[0];
  assign SPEAKER_TIMER_PIN    = outs[2];

  wire [7:0] rd_mux = sel0 ? rd0 : sel1 ? rd1 : rd2;
  // data from a read lands two cycles after the strobe edge; 043 never drives
  wire rd_oe = !rd_n_s && (sel0 || sel1 || sel2 || selg);

  // arbiter inputs
  wire out1_rise = outs[1] && !out1_d_r;
  wire in_ref    = st_r == ARB_REF || st_r == ARB_RWAIT;
  // own release needs two sync cycles to reach the pin copy, so mask that tail
  wire ext_low   = !refin_s && !oe_r && oe_d_r == 2'b00;
  wire ref_start = st_nxt == ARB_REF && st_r != ARB_REF;
  wire ref_done  = st_r == ARB_REF && sclk_rise &&
                   edges_r >= 3'(REFRESH_EDGES - 1) && rdy_s;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ARB_IDLE: begin
        if (ext_low) st_nxt = ARB_EXT;
        else if (dma_pend_r) st_nxt = ARB_DWAIT;
        else if (ref_pend_r) st_nxt = ARB_RWAIT;
      end
      ARB_DWAIT: if (hlda_s) st_nxt = ARB_DMA;
      ARB_DMA: begin
        if (!dreq_s) st_nxt = ref_pend_r ? ARB_REF : ARB_IDLE;
      end
      ARB_RWAIT: if (hlda_s) st_nxt = ARB_REF;
      ARB_REF: begin
        if (ref_done) st_nxt = dma_pend_r ? ARB_DMA : ARB_IDLE;
      end
      ARB_EXT: if (refin_s) st_nxt = ARB_IDLE;
      default: st_nxt = ARB_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cclk_d_r <= 1'b0; sclk_d_r <= 1'b0; dclk_d_r <= 1'b0;
      rd_n_d_r <= 1'b1; wr_n_d_r <= 1'b1; out1_d_r <= 1'b0;
      gate2_r  <= 1'b0; IO_RDATA <= 8'h00; rd_go_r <= 1'b0;
      bus_m_r  <= 16'h0000; bus_s_r <= 16'h0000;
    end else begin
      cclk_d_r <= cclk_s; sclk_d_r <= sclk_s; dclk_d_r <= dclk_s;
      rd_n_d_r <= rd_n_s; wr_n_d_r <= wr_n_s; out1_d_r <= outs[1];
      bus_m_r  <= {IO_ADDR, IO_WDATA}; bus_s_r <= bus_m_r;
      // counter read data settles one cycle after the strobe edge
      rd_go_r  <= io_rd && (sel0 || sel1 || sel2 || selg);
      if (io_wr && selg) gate2_r <= wdata_s[GATE_BIT];
      if (rd_go_r) IO_RDATA <= selg ? {7'h00, gate2_r} : rd_mux;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r <= ARB_IDLE; ref_pend_r <= 1'b0; dma_pend_r <= 1'b0;
      edges_r <= 3'h0; oe_r <= 1'b0; ref_raw_r <= 1'b0; oe_d_r <= 2'b00;
    end else begin
      st_r <= st_nxt;
      oe_d_r <= {oe_d_r[0], oe_r};
      // sample on opposite dma clock phases so neither source is favoured
      if (dclk_rise) dma_pend_r <= dreq_s;
      else if (!dreq_s) dma_pend_r <= 1'b0;
      // counter edge is sticky until its refresh starts; a new edge beats the clear
      if (out1_rise) ref_raw_r <= 1'b1;
      else if (ref_start) ref_raw_r <= 1'b0;
      if (dclk_fall) ref_pend_r <= ref_raw_r && !ref_start;
      else if (ref_start) ref_pend_r <= 1'b0;
      if (ref_start) begin
        edges_r <= 3'h0; oe_r <= 1'b1;
      end else if (st_r == ARB_REF && sclk_rise) begin
        if (edges_r < 3'(REFRESH_EDGES - 1)) edges_r <= edges_r + 3'h1;
        if (ref_done) oe_r <= 1'b0;
      end
    end
  end

  assign IO_RDATA_OE       = rd_oe;
  assign DMA_HOLD_ACK      = st_r == ARB_DMA;
  assign HOST_HOLD_REQUEST = st_r != ARB_IDLE && st_r != ARB_EXT;
  assign REFRESH_OUT       = 1'b0;
  assign REFRESH_OE        = oe_r;
endmodule // hart_top

// ### bench/hart_properties.sv
`timescale 1ns/1ps
module hart_properties
  import hart_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       RSTN,
  input wire logic [7:0] IO_ADDR,
  input wire logic       IO_RDATA_OE,
  input wire logic       DMA_HOLD_REQ,
  input wire logic       DMA_HOLD_ACK,
  input wire logic       HOST_HOLD_REQUEST,
  input wire logic       HOST_HOLD_GRANT,
  input wire logic       CHANNEL_READY_EXTEND,
  input wire logic       REFRESH_OUT,
  input wire logic       REFRESH_OE
);
  logic [7:0] len_r;
  logic       rlow_r;
  logic [4:0] dq_r;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);
  // strobe spans far more cycles than a repetition may, so count them here
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      len_r  <= 8'h00;
      rlow_r <= 1'b0;
      dq_r   <= 5'h00;
    end else begin
      len_r  <= REFRESH_OE ? len_r + 8'h01 : 8'h00;
      rlow_r <= REFRESH_OE && (rlow_r || !CHANNEL_READY_EXTEND);
      dq_r   <= !DMA_HOLD_REQ ? 5'h00 : (dq_r == 5'h1f) ? dq_r : dq_r + 5'h01;
    end
  end
  a_ack_needs_grant: assert property ($rose(DMA_HOLD_ACK) |-> HOST_HOLD_GRANT)
    else $error("dma ack before host grant");
  a_strobe_needs_grant: assert property ($rose(REFRESH_OE) |-> HOST_HOLD_GRANT)
    else $error("strobe driven before host grant");
  a_drive_low_only: assert property (REFRESH_OUT == 1'b0)
    else $error("strobe driven high");
  a_single_owner: assert property (!(REFRESH_OE && DMA_HOLD_ACK))
    else $error("refresh and dma granted together");
  a_ctrl_read_quiet: assert property ((IO_ADDR == CTRL_ADDR)[*3] |-> !IO_RDATA_OE)
    else $error("read at control port drives data");
  a_strobe_min_len: assert property ($fell(REFRESH_OE) |-> $past(len_r) >= 8'h14)
    else $error("refresh strobe too short");
  a_strobe_max_len: assert property (REFRESH_OE && !rlow_r |-> len_r < 8'h28)
    else $error("refresh strobe too long");
  a_ready_stretch: assert property
    ((REFRESH_OE && !CHANNEL_READY_EXTEND)[*5] |=> REFRESH_OE)
    else $error("strobe released while ready low");
  a_dma_raises_req: assert property (dq_r == 5'h14 |-> HOST_HOLD_REQUEST)
    else $error("dma request not forwarded to host");
  a_ack_has_hold: assert property (DMA_HOLD_ACK |-> HOST_HOLD_REQUEST)
    else $error("dma ack without host hold request");
  a_strobe_end_free: assert property
    ($fell(REFRESH_OE) |-> !HOST_HOLD_REQUEST || DMA_HOLD_ACK)
    else $error("host hold kept after refresh");
endmodule // hart_properties

// ### bench/hart_host_model.sv
`timescale 1ns/1ps
module hart_host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic req,
  input  wire logic slow,
  output logic      grant
);
  logic [3:0] wait_r;
  // host ends its own bus cycle before granting; slow mode mimics a long one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 4'h0;
      grant  <= 1'b0;
    end else if (!req) begin
      wait_r <= 4'h0;
      grant  <= 1'b0;
    end else if (wait_r == (slow ? 4'hc : 4'h2)) begin
      grant  <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule // hart_host_model

// ### bench/tb_hart_top.sv
`timescale 1ns/1ps
module tb_hart_top;
  import hart_pkg::*;
  logic        ref_clk = 1'b0, cnt_clk = 1'b0, bus_clk = 1'b0, dma_clk = 1'b0, oe_d = 1'b0;
  logic        rstn, rd_n, wr_n, dma_req, rdy, ext_low, slow;
  logic        rdata_oe, irq, spk, dma_ack, host_req, host_gnt, ref_out, ref_oe;
  logic [7:0]  io_addr, wdata, rdata;
  logic [1:0]  hl;
  logic [15:0] v;
  logic [7:0]  exp_q[$];
  wire         ref_in;
  int          fail_count = 0;
  int          n_tests = 0;

  always #2.5 ref_clk = ~ref_clk;
  always #20 dma_clk = ~dma_clk;
  always #20 bus_clk = ~bus_clk;
  always #40 cnt_clk = ~cnt_clk;
  // pull-up on the strobe line; an outside agent may pull it low
  assign ref_in = !(ref_oe && !ref_out) && !ext_low;

  hart_top DUT (
    .REF_CLK(ref_clk), .RSTN(rstn), .COUNTER_CLOCK_INPUT(cnt_clk),
    .SYSTEM_BUS_CLOCK(bus_clk), .DMA_CLOCK(dma_clk), .IO_ADDR(io_addr),
    .PERIPHERAL_IO_READ_N(rd_n), .PERIPHERAL_IO_WRITE_N(wr_n), .IO_WDATA(wdata),
    .IO_RDATA(rdata), .IO_RDATA_OE(rdata_oe), .TIMER_INTERRUPT_LINE(irq),
    .SPEAKER_TIMER_PIN(spk), .DMA_HOLD_REQ(dma_req), .DMA_HOLD_ACK(dma_ack),
    .HOST_HOLD_REQUEST(host_req), .HOST_HOLD_GRANT(host_gnt),
    .CHANNEL_READY_EXTEND(rdy), .REFRESH_IN(ref_in), .REFRESH_OUT(ref_out),
    .REFRESH_OE(ref_oe)
  );
  hart_host_model u_host (.clk(ref_clk), .rst_n(rstn), .req(host_req), .slow(slow),
    .grant(host_gnt));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return ref_oe;
      1: return dma_ack;
      2: return host_req;
      3: return irq;
      default: return spk;
    endcase
  endfunction
  task automatic wait_on(input int w, input logic val, input int lim);
    int k;
    k = 0;
    while (sel(w) !== val && k < lim) begin
      @(negedge ref_clk);
      k++;
    end
    check(8'(sel(w)), 8'(val));
  endtask
  task automatic watch(input int w, output logic [1:0] seen);
    seen = 2'b00;
    repeat (200) begin
      @(negedge ref_clk);
      seen |= {sel(w), !sel(w)};
    end
  endtask
  // strobes held six cycles, well above the three the synchronisers need
  task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a;
    wdata = d;
    if (wr) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    wr_n = 1'b1;
    rd_n = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    io(1'b0, a, 8'h00);
  endtask
  task automatic finish_test();
    // a read whose data never showed up still owes its comparison
    if (exp_q.size() != 0) fail_count++;
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(negedge ref_clk) begin
    oe_d <= rdata_oe;
    if (oe_d && !rdata_oe) check(rdata, exp_q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    {rstn, dma_req, ext_low, slow} = 4'b0000;
    {rd_n, wr_n, rdy} = 3'b111;
    io_addr = 8'h00;
    wdata = 8'h00;
    v = 16'($urandom(32'hd5fe761b));
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    io(1'b1, CTRL_ADDR, 8'hb0);
    io(1'b1, CNT2_ADDR, v[7:0]);
    io(1'b1, CNT2_ADDR, v[15:8]);
    repeat (40) @(negedge ref_clk);
    io(1'b1, CTRL_ADDR, 8'h80);
    rd(CNT2_ADDR, v[7:0]);
    rd(CNT2_ADDR, v[15:8]);
    io(1'b1, CTRL_ADDR, 8'he8);
    rd(CNT2_ADDR, 8'h30);
    io(1'b0, CTRL_ADDR, 8'h00);
    $display("test latch done");
    io(1'b1, CTRL_ADDR, 8'h34);
    io(1'b1, CNT0_ADDR, 8'h03);
    io(1'b1, CNT0_ADDR, 8'h00);
    watch(3, hl);
    check(8'(hl), 8'h03);
    $display("test counter zero done");
    io(1'b1, CTRL_ADDR, 8'hb6);
    io(1'b1, CNT2_ADDR, 8'h04);
    io(1'b1, CNT2_ADDR, 8'h00);
    watch(4, hl);
    check(8'(hl), 8'h02);
    io(1'b1, GATE_ADDR, 8'($urandom) | 8'h01);
    watch(4, hl);
    check(8'(hl), 8'h03);
    rd(GATE_ADDR, 8'h01);
    io(1'b1, GATE_ADDR, 8'($urandom) & 8'hfe);
    $display("test speaker gate done");
    io(1'b1, CTRL_ADDR, 8'h74);
    io(1'b1, CNT1_ADDR, 8'h0a);
    io(1'b1, CNT1_ADDR, 8'h00);
    wait_on(0, 1'b1, 600);
    check(8'(host_gnt), 8'h01);
    wait_on(0, 1'b0, 60);
    repeat (3) @(negedge ref_clk);
    check(8'(host_req), 8'h00);
    $display("test refresh done");
    wait_on(0, 1'b1, 400);
    rdy = 1'b0;
    repeat (80) @(negedge ref_clk);
    check(8'(ref_oe), 8'h01);
    rdy = 1'b1;
    wait_on(0, 1'b0, 40);
    $display("test ready stretch done");
    slow = 1'b1;
    dma_req = 1'b1;
    wait_on(2, 1'b1, 30);
    check(8'(dma_ack), 8'h00);
    wait_on(1, 1'b1, 40);
    repeat (200 + $urandom % 64) @(negedge ref_clk);
    dma_req = 1'b0;
    wait_on(0, 1'b1, 40);
    check(8'(host_req), 8'h01);
    slow = 1'b0;
    $display("test dma then refresh done");
    dma_req = 1'b1;
    wait_on(0, 1'b0, 80);
    wait_on(1, 1'b1, 10);
    check(8'(host_req), 8'h01);
    dma_req = 1'b0;
    wait_on(2, 1'b0, 20);
    $display("test refresh then dma done");
    wait_on(0, 1'b1, 400);
    wait_on(0, 1'b0, 60);
    repeat (5) @(negedge ref_clk);
    ext_low = 1'b1;
    // long enough to span a counter one edge, which must not start a refresh
    repeat (200) @(negedge ref_clk);
    check(8'({host_req, ref_oe}), 8'h00);
    ext_low = 1'b0;
    $display("test outside refresh done");
    finish_test();
  end
endmodule // tb_hart_top

bind hart_top hart_properties u_props (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .IO_ADDR(IO_ADDR), .IO_RDATA_OE(IO_RDATA_OE),
  .DMA_HOLD_REQ(DMA_HOLD_REQ), .DMA_HOLD_ACK(DMA_HOLD_ACK),
  .HOST_HOLD_REQUEST(HOST_HOLD_REQUEST), .HOST_HOLD_GRANT(HOST_HOLD_GRANT),
  .CHANNEL_READY_EXTEND(CHANNEL_READY_EXTEND), .REFRESH_OUT(REFRESH_OUT),
  .REFRESH_OE(REFRESH_OE)
);
